// [hdl/hfc_counter.sv]
// Gated pulse frequency and pulse width counter with Avalon-MM registers.
// Function
// - Start while input high, both edges: interrupt.
// - Pulse width counts falls of input AND source.
// - Frequency mode counts input edges during gate high.
// - Gate source 00 selects the gate pin.
// - Gate interrupt on falling or both edges.
// - Uncleared counter resumes from its held value.
// - Window status flag shows the gate state.
// - Wrap to zero sets sticky overflow until clear.
// - Output disable only gates companion wave to pin.
// - Internal gate alternates high and low periods.
// - Each period lasts sixteen minus setting ticks.
// - First internal window may start one tick late.
// - Low setting written in low applies next low.
// - Both-edge count adds one at gate fall.
// - Single-edge counts falls of input AND gate.
// - Window status zero unless counting in high period.
// - Gate source 01 internal, 10 companion, 11 reserved.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
module hfc_counter
	import hfc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Avalon-MM slave.
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// External signals.
	input wire logic measuredPulseInput,
	input wire logic gatePinInput,
	input wire logic companionWaveOutput,
	input wire logic slowClockTick,
	// Outputs.
	output logic gateOutputPin,
	output logic timerEventIrq
);
	// Control registers, status and counter.
	hfc_ctrl_type ctrl_q;
	logic [7:0] period_q;
	logic [CNT_W-1:0] count_q, count_d;
	logic overflow_q;
	logic ack_q;
	logic [31:0] readdata_q;
	// Synchronisers and edge history.
	logic [1:0] inSync_q, gateSync_q;
	logic inPrev_q, gatePrev_q, andPrev_q, wave_q;
	// Prescalers.
	logic [PRE_W-1:0] pre_q;
	logic [SLOW_W-1:0] slow_q;
	// Every check below samples on the system clock and rests in reset.
	default clocking cbSys @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Bus decode: one wait cycle, accepted when waitrequest is low.
	wire logic access = read || write;
	wire logic accept = access && ack_q;
	wire logic wrEn = write && accept && byteenable[0];
	wire logic wrCtrlOne = wrEn && (address == OFS_CTRL_ONE);
	wire logic wrCtrlTwo = wrEn && (address == OFS_CTRL_TWO);
	wire logic wrPeriod = wrEn && (address == OFS_PERIOD);
	wire logic [1:0] newRun = writedata[RUN_LSB+1:RUN_LSB];
	wire logic clearCmd = wrCtrlOne && writedata[CLEAR_BIT];
	assign waitrequest = access && !ack_q;
	assign readdata = readdata_q;

	// Decoded controls.
	wire logic running = (ctrl_q.runControl == RUN_START);
	wire logic freqMode = (ctrl_q.mode == MODE_FREQUENCY);
	wire logic pwMode = (ctrl_q.mode == MODE_PULSE_WIDTH);

	// Synchronised measured input and its edges.
	wire logic inLevel = inSync_q[1];
	wire logic inRise = inLevel && !inPrev_q;
	wire logic inFall = !inLevel && inPrev_q;

	// Gate ticks from the fast or slow prescaler.
	wire logic fastTick0 = &pre_q[FAST_SH0-1:0];
	wire logic fastTick1 = &pre_q[FAST_SH0:0];
	wire logic fastTick2 = &pre_q[FAST_SH0+1:0];
	wire logic slowTick0 = slowClockTick && (&slow_q[SLOW_SH0-1:0]);
	wire logic slowTick1 = slowClockTick && (&slow_q[SLOW_SH0:0]);
	wire logic slowTick2 = slowClockTick && (&slow_q[SLOW_SH0+1:0]);
	wire logic fastTick = (ctrl_q.gateClockSelect == 2'h0) ? fastTick0 :
		(ctrl_q.gateClockSelect == 2'h1) ? fastTick1 :
		(ctrl_q.gateClockSelect == 2'h2) ? fastTick2 : 1'b0;
	wire logic slowTick = (ctrl_q.gateClockSelect == 2'h0) ? slowTick0 :
		(ctrl_q.gateClockSelect == 2'h1) ? slowTick1 :
		(ctrl_q.gateClockSelect == 2'h2) ? slowTick2 : 1'b0;
	wire logic gateTick = ctrl_q.prescalerTapSelect ? slowTick : fastTick;

	// Internal gate generator runs only while it is the chosen source.
	wire logic internalGate;
	wire logic genEnable = running && freqMode &&
		(ctrl_q.gateSourceSelect == GSRC_INTERNAL);
	hfc_gate_gen gateGen (
		.clk(clk),
		.reset_n(reset_n),
		.enable(genEnable),
		.tick(gateTick),
		.highSetting(period_q[HIGHSET_LSB+3:HIGHSET_LSB]),
		.lowSetting(period_q[LOWSET_LSB+3:LOWSET_LSB]),
		.gateHigh(internalGate)
	);

	// Gate selection; the reserved code gives a gate that never opens.
	wire logic gateLevel =
		(ctrl_q.gateSourceSelect == GSRC_PIN) ? gateSync_q[1] :
		(ctrl_q.gateSourceSelect == GSRC_INTERNAL) ? internalGate :
		(ctrl_q.gateSourceSelect == GSRC_COMPANION) ? wave_q : 1'b0;
	wire logic gateRise = gateLevel && !gatePrev_q;
	wire logic gateFall = !gateLevel && gatePrev_q;

	// Source clock level for pulse width mode.
	wire logic srcLevel = (ctrl_q.countSourceSelect == SRC_DIV8) ?
		pre_q[DIV8_BIT] : (ctrl_q.countSourceSelect == SRC_DIV128) ?
		pre_q[DIV128_BIT] : pre_q[DIV2K_BIT];

	// AND term whose falling edge is counted in either mode.
	wire logic andLevel = freqMode ? (inLevel && gateLevel) :
		(inLevel && srcLevel);
	wire logic andFall = andPrev_q && !andLevel;

	// Count events.
	wire logic pwCount = running && pwMode &&
		(ctrl_q.countSourceSelect != SRC_EXTERNAL) && andFall;
	wire logic extSel = (ctrl_q.countSourceSelect == SRC_EXTERNAL);
	wire logic bothCount = ctrl_q.bothEdgeCountSelect &&
		((gateLevel && (inRise || inFall)) || gateFall);
	wire logic singleCount = !ctrl_q.bothEdgeCountSelect && andFall;
	wire logic fqCount = running && freqMode && extSel &&
		(bothCount || singleCount);
	wire logic countEvent = pwCount || fqCount;
	wire logic wrap = countEvent && (count_q == CNT_MAX);

	// Interrupt events.
	wire logic pwIrq = running && pwMode &&
		(inFall || (inRise && ctrl_q.gateIrqEdgeSelect));
	wire logic startIrq = wrCtrlOne && pwMode && !running && inLevel &&
		(newRun == RUN_START) && ctrl_q.gateIrqEdgeSelect;
	wire logic stopIrq = wrCtrlOne && pwMode && running && inLevel &&
		(newRun == RUN_STOP);
	wire logic fqIrq = running && freqMode && (gateFall ||
		(gateRise && ctrl_q.gateIrqEdgeSelect));

	// Counter next value: a clear wins, otherwise the held value grows.
	always_comb begin
		count_d = count_q;
		if (clearCmd) begin
			count_d = CNT_ZERO;
		end else if (countEvent) begin
			count_d = count_q + 18'h0_0001;
		end
	end

	// Status read image.
	wire logic windowCount = running && freqMode && gateLevel;
	wire logic [31:0] statusWord = ({31'h0, windowCount} << WCS_BIT) |
		({31'h0, overflow_q} << OVF_BIT);

	// Read multiplexer; unmapped addresses read as zero.
	logic [31:0] readMux;
	always_comb begin
		readMux = 32'h0000_0000;
		unique case (address)
			OFS_CTRL_ONE: begin
				readMux = ({30'h0, ctrl_q.runControl} << RUN_LSB) |
					({31'h0, ctrl_q.mode} << MODE_BIT) |
					({30'h0, ctrl_q.countSourceSelect} << SRC_LSB);
			end
			OFS_CTRL_TWO: begin
				readMux = ({30'h0, ctrl_q.gateSourceSelect} << GSRC_LSB) |
					({31'h0, ctrl_q.gateIrqEdgeSelect} << GEDGE_BIT) |
					({30'h0, ctrl_q.gateClockSelect} << GCLK_LSB) |
					({31'h0, ctrl_q.bothEdgeCountSelect} << BOTH_BIT) |
					({31'h0, ctrl_q.gateOutputDisable} << GOUT_BIT) |
					({31'h0, ctrl_q.prescalerTapSelect} << TAP_BIT);
			end
			OFS_STATUS: begin
				readMux = statusWord;
			end
			OFS_RESULT: begin
				readMux = {14'h0000, count_q};
			end
			OFS_PERIOD: begin
				readMux = {24'h00_0000, period_q};
			end
			default: begin
				readMux = 32'h0000_0000;
			end
		endcase
	end

	// Bus handshake and read data register.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= access && !ack_q;
			readdata_q <= (read && !ack_q) ? readMux : readdata_q;
		end
	end

	// Control registers, written on the accepting edge only.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_q <= '0;
			period_q <= 8'h00;
		end else begin
			if (wrCtrlOne) begin
				ctrl_q.runControl <= newRun;
				ctrl_q.mode <= hfc_mode_type'(writedata[MODE_BIT]);
				ctrl_q.countSourceSelect <= writedata[SRC_LSB+1:SRC_LSB];
			end
			if (wrCtrlTwo) begin
				ctrl_q.gateSourceSelect <= writedata[GSRC_LSB+1:GSRC_LSB];
				ctrl_q.gateIrqEdgeSelect <= writedata[GEDGE_BIT];
				ctrl_q.gateClockSelect <= writedata[GCLK_LSB+1:GCLK_LSB];
				ctrl_q.bothEdgeCountSelect <= writedata[BOTH_BIT];
				ctrl_q.gateOutputDisable <= writedata[GOUT_BIT];
				ctrl_q.prescalerTapSelect <= writedata[TAP_BIT];
			end
			if (wrPeriod) begin
				period_q <= writedata[7:0];
			end
		end
	end

	// Counter and sticky overflow; a wrap in the clear cycle still sets it.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_q <= CNT_ZERO;
			overflow_q <= 1'b0;
		end else begin
			count_q <= count_d;
			overflow_q <= wrap || (overflow_q && !clearCmd);
		end
	end

	// Two-flop synchronisers; only the second stage is looked at.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inSync_q <= 2'b00;
			gateSync_q <= 2'b00;
		end else begin
			inSync_q <= {inSync_q[0], measuredPulseInput};
			gateSync_q <= {gateSync_q[0], gatePinInput};
		end
	end

	// Edge history, prescalers and registered outputs.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inPrev_q <= 1'b0;
			gatePrev_q <= 1'b0;
			andPrev_q <= 1'b0;
			wave_q <= 1'b0;
			pre_q <= '0;
			slow_q <= '0;
			gateOutputPin <= 1'b0;
			timerEventIrq <= 1'b0;
		end else begin
			inPrev_q <= inLevel;
			gatePrev_q <= gateLevel;
			andPrev_q <= andLevel;
			wave_q <= companionWaveOutput;
			pre_q <= pre_q + 14'h0001;
			slow_q <= slowClockTick ? slow_q + 6'h01 : slow_q;
			// The companion wave is only masked, never stopped here.
			gateOutputPin <= companionWaveOutput &&
				!ctrl_q.gateOutputDisable;
			timerEventIrq <= pwIrq || startIrq || stopIrq || fqIrq;
		end
	end

	// Checks; each takes the default clock and reset declared above.
	a_start_irq_pw: assert property (
		startIrq |=> timerEventIrq)
		else $error("start while input high gave no interrupt");
	a_fall_irq_fq: assert property (
		running && freqMode && gateFall |=> timerEventIrq)
		else $error("gate fall gave no interrupt");
	a_rise_irq_sel: assert property (
		running && freqMode && gateRise && !ctrl_q.gateIrqEdgeSelect
		|=> !timerEventIrq)
		else $error("rise interrupt without both-edge select");
	a_wrap_sets_ovf: assert property (
		wrap |=> overflow_q && count_q == CNT_ZERO)
		else $error("wrap did not set overflow");
	a_ovf_sticky: assert property (
		overflow_q && !clearCmd |=> overflow_q)
		else $error("overflow dropped without clear");
	a_count_hold: assert property (
		!countEvent && !clearCmd |=> $stable(count_q))
		else $error("counter moved without an event");
	a_no_count_low: assert property (
		freqMode && !ctrl_q.bothEdgeCountSelect && !gatePrev_q &&
		!gateLevel |-> !fqCount)
		else $error("counted while gate closed");
	a_status_gate: assert property (
		!running |-> !statusWord[WCS_BIT])
		else $error("window status set while stopped");
	a_pin_gate_src: assert property (
		ctrl_q.gateSourceSelect == GSRC_PIN |-> gateLevel == gateSync_q[1])
		else $error("gate pin not selected");
	a_bus_one_wait: assert property (
		access && !ack_q |=> !waitrequest || !access)
		else $error("bus answer took more than one wait cycle");
	c_wrap_seen: cover property (wrap);
	c_fq_irq: cover property (fqIrq);
	c_pw_count: cover property (pwCount);
	c_int_gate: cover property (internalGate && fqCount);
endmodule
`default_nettype wire

// [hdl/hfc_pkg.sv]
// Package of constants and types for the gated pulse frequency counter.
`default_nettype none
package hfc_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] OFS_CTRL_ONE = 5'h00;
	localparam logic [4:0] OFS_CTRL_TWO = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_RESULT = 5'h0C;
	localparam logic [4:0] OFS_PERIOD = 5'h10;
	// Field positions in timer_control_one.
	localparam int RUN_LSB = 0;
	localparam int CLEAR_BIT = 2;
	localparam int MODE_BIT = 3;
	localparam int SRC_LSB = 4;
	// Field positions in timer_control_two.
	localparam int GSRC_LSB = 0;
	localparam int GEDGE_BIT = 2;
	localparam int GCLK_LSB = 3;
	localparam int BOTH_BIT = 5;
	localparam int GOUT_BIT = 6;
	localparam int TAP_BIT = 7;
	// Field positions in timer_status and gate_period_reg.
	localparam int WCS_BIT = 7;
	localparam int OVF_BIT = 6;
	localparam int LOWSET_LSB = 0;
	localparam int HIGHSET_LSB = 4;
	// Run control codes.
	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_START = 2'h2;
	// Gate source codes.
	localparam logic [1:0] GSRC_PIN = 2'h0;
	localparam logic [1:0] GSRC_INTERNAL = 2'h1;
	localparam logic [1:0] GSRC_COMPANION = 2'h2;
	// Count source codes: external input or a prescaler tap.
	localparam logic [1:0] SRC_EXTERNAL = 2'h0;
	localparam logic [1:0] SRC_DIV8 = 2'h1;
	localparam logic [1:0] SRC_DIV128 = 2'h2;
	// Prescaler bits whose level forms the internal source clocks.
	localparam int DIV8_BIT = 2;
	localparam int DIV128_BIT = 6;
	localparam int DIV2K_BIT = 10;
	// Prescaler widths for gate ticks, fast and slow.
	localparam int PRE_W = 14;
	localparam int FAST_SH0 = 12;
	localparam int SLOW_W = 6;
	localparam int SLOW_SH0 = 4;
	// Counter geometry.
	localparam int CNT_W = 18;
	localparam logic [CNT_W-1:0] CNT_MAX = 18'h3_FFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 18'h0_0000;
	// Internal gate period: (16 - setting) ticks.
	localparam logic [4:0] GATE_BASE = 5'h10;
	// Measurement modes.
	typedef enum logic {
		MODE_PULSE_WIDTH = 1'b0,
		MODE_FREQUENCY = 1'b1
	} hfc_mode_type;
	// Control fields gathered from the two control registers.
	typedef struct packed {
		logic [1:0] runControl;
		hfc_mode_type mode;
		logic [1:0] countSourceSelect;
		logic [1:0] gateSourceSelect;
		logic gateIrqEdgeSelect;
		logic [1:0] gateClockSelect;
		logic bothEdgeCountSelect;
		logic gateOutputDisable;
		logic prescalerTapSelect;
	} hfc_ctrl_type;
endpackage
`default_nettype wire

// [hdl/hfc_gate_gen.sv]
// Internal window gate generator with separate high and low periods.
`default_nettype none
module hfc_gate_gen
	import hfc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Control.
	input wire logic enable,
	input wire logic tick,
	input wire logic [3:0] highSetting,
	input wire logic [3:0] lowSetting,
	// Gate level.
	output logic gateHigh
);
	typedef enum logic [1:0] {
		GG_IDLE = 2'b00,
		GG_HIGH = 2'b01,
		GG_LOW = 2'b10
	} hfc_gg_state_type;

	// Phase state and remaining ticks in the phase.
	hfc_gg_state_type state_q, state_d;
	logic [4:0] left_q, left_d;
	wire logic lastTick = tick && (left_q == 5'h01);

	// The first window waits for a tick, so it may start one tick late.
	always_comb begin
		state_d = state_q;
		left_d = left_q;
		unique case (state_q)
			GG_IDLE: begin
				if (enable && tick) begin
					state_d = GG_HIGH;
					left_d = GATE_BASE - {1'b0, highSetting};
				end
			end
			GG_HIGH: begin
				if (!enable) begin
					state_d = GG_IDLE;
				end else if (lastTick) begin
					// Low length is sampled as the low phase starts.
					state_d = GG_LOW;
					left_d = GATE_BASE - {1'b0, lowSetting};
				end else if (tick) begin
					left_d = left_q - 5'h01;
				end
			end
			GG_LOW: begin
				if (!enable) begin
					state_d = GG_IDLE;
				end else if (lastTick) begin
					state_d = GG_HIGH;
					left_d = GATE_BASE - {1'b0, highSetting};
				end else if (tick) begin
					left_d = left_q - 5'h01;
				end
			end
			default: begin
				state_d = GG_IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= GG_IDLE;
			left_q <= 5'h00;
		end else begin
			state_q <= state_d;
			left_q <= left_d;
		end
	end

	assign gateHigh = (state_q == GG_HIGH);

	// A running high or low phase never lasts beyond sixteen ticks.
	a_gate_len_bound: assert property (
		@(posedge clk) disable iff (!reset_n)
		state_q != GG_IDLE |-> left_q >= 5'h01 && left_q <= GATE_BASE)
		else $error("gate phase length out of range");
endmodule
`default_nettype wire

// [tb/hfc_pulse_source.sv]
// Model of the pulse source, window gate, companion wave and slow clock.
`default_nettype none
module hfc_pulse_source (
	// Clock.
	input wire logic clk,
	// Signals into the counter.
	output logic measuredPulseInput,
	output logic gatePinInput,
	output logic companionWaveOutput,
	output logic slowClockTick
);
	timeunit 1ns;
	timeprecision 100ps;
	// All lines start low so the counter sees a quiet world.
	initial begin
		measuredPulseInput = 1'b0;
		gatePinInput = 1'b0;
		companionWaveOutput = 1'b0;
		slowClockTick = 1'b0;
	end
	// A slow tick every second cycle keeps internal gate periods short.
	always @(posedge clk) begin
		slowClockTick <= ~slowClockTick;
	end
	// Each level lasts several cycles, so the synchroniser cannot miss it.
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			measuredPulseInput <= 1'b1;
			repeat (4) @(posedge clk);
			measuredPulseInput <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	// Sets the three levels together just after an edge.
	task automatic drive(input logic inp, input logic gate, input logic comp);
		@(posedge clk);
		measuredPulseInput <= inp;
		gatePinInput <= gate;
		companionWaveOutput <= comp;
	endtask
endmodule
`default_nettype wire

// [tb/test_gated_pulse_frequency_counter.sv]
// Self-checking testbench of the gated pulse frequency counter.
`default_nettype none
module test_gated_pulse_frequency_counter
	import hfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	wire logic measuredPulseInput;
	wire logic gatePinInput;
	wire logic companionWaveOutput;
	wire logic slowClockTick;
	logic gateOutputPin;
	logic timerEventIrq;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	int irqCount = 0;
	int irqTime = 0;
	// The block under test.
	hfc_counter i_hfc_counter (.clk(clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.measuredPulseInput(measuredPulseInput),
		.gatePinInput(gatePinInput),
		.companionWaveOutput(companionWaveOutput),
		.slowClockTick(slowClockTick), .gateOutputPin(gateOutputPin),
		.timerEventIrq(timerEventIrq));
	// The far side.
	hfc_pulse_source i_hfc_pulse_source (.clk(clk),
		.measuredPulseInput(measuredPulseInput),
		.gatePinInput(gatePinInput),
		.companionWaveOutput(companionWaveOutput),
		.slowClockTick(slowClockTick));
	// A 25 ns clock.
	always #12.5 clk = ~clk;
	// Interrupt pulses are counted and time-stamped in cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (timerEventIrq === 1'b1) begin
			irqCount <= irqCount + 1;
			irqTime <= cyc;
		end
	end
	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One Avalon transfer; the request stands until waitrequest is low.
	task automatic bus(input logic wr, input logic [4:0] adr,
		input logic [31:0] wd, output logic [31:0] rd);
		int t;
		t = 0;
		@(posedge clk);
		address <= adr;
		writedata <= wd;
		write <= wr;
		read <= ~wr;
		// Waitrequest is judged at the rising edge, as the slave sees it.
		do begin
			@(posedge clk);
			t++;
		end while (waitrequest !== 1'b0 && t < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (t >= 50) n_fail++;
	endtask
	task automatic regWrite(input logic [4:0] adr, input logic [31:0] wd);
		logic [31:0] rd;
		bus(1'b1, adr, wd, rd);
	endtask
	task automatic regRead(input logic [4:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, adr, 32'h0000_0000, rd);
		check("register", exp, rd);
	endtask
	// Waits, bounded, for the next interrupt pulse and returns its cycle.
	task automatic waitIrq(output int at);
		int c0;
		c0 = irqCount;
		repeat (600) begin
			@(negedge clk);
			if (irqCount != c0) break;
		end
		at = irqTime;
		check("irq seen", 32'h0000_0001, 32'(irqCount != c0));
	endtask
	// Reset values and an unmapped address.
	task automatic test_reset_regs();
		regRead(OFS_STATUS, 32'h0000_0000);
		regRead(OFS_RESULT, 32'h0000_0000);
		regRead(OFS_CTRL_TWO, 32'h0000_0000);
		regRead(5'h14, 32'h0000_0000);
	endtask
	// Two pin-gated windows without a clear in between, then a clear.
	task automatic test_freq_pin();
		int n0;
		regWrite(OFS_CTRL_TWO, 32'h0000_0000);
		regWrite(OFS_CTRL_ONE, 32'h0000_000E);
		n0 = irqCount;
		for (int w = 0; w < 2; w++) begin
			i_hfc_pulse_source.drive(1'b0, 1'b1, 1'b0);
			repeat (6) @(posedge clk);
			regRead(OFS_STATUS, 32'h0000_0080);
			i_hfc_pulse_source.pulses(w == 0 ? 5 : 3);
			i_hfc_pulse_source.drive(1'b0, 1'b0, 1'b0);
			repeat (8) @(posedge clk);
			regRead(OFS_RESULT, w == 0 ? 32'h5 : 32'h8);
			regRead(OFS_STATUS, 32'h0000_0000);
		end
		check("fall irqs", 32'(n0 + 2), 32'(irqCount));
		// Clear first while the gate is low, then read the result back as zero.
		regWrite(OFS_CTRL_ONE, 32'h0000_000E);
		regRead(OFS_RESULT, 32'h0000_0000);
	endtask
	// A constant high input counts one per window in either edge mode.
	task automatic test_const_input();
		int n0;
		for (int s = 0; s < 2; s++) begin
			regWrite(OFS_CTRL_TWO, s == 1 ? 32'h24 : 32'h00);
			regWrite(OFS_CTRL_ONE, 32'h0000_000E);
			i_hfc_pulse_source.drive(1'b1, 1'b0, 1'b0);
			repeat (6) @(posedge clk);
			n0 = irqCount;
			i_hfc_pulse_source.drive(1'b1, 1'b1, 1'b0);
			repeat (10) @(posedge clk);
			i_hfc_pulse_source.drive(1'b1, 1'b0, 1'b0);
			repeat (8) @(posedge clk);
			regRead(OFS_RESULT, 32'h0000_0001);
			check("gate irqs", 32'(n0 + 1 + s), 32'(irqCount));
		end
		i_hfc_pulse_source.drive(1'b0, 1'b0, 1'b0);
	endtask
	// Start and stop in pulse width mode while the input is high.
	// The run spans ten edges, so the clk/8 level falls once or twice.
	task automatic test_pulse_width();
		int n0;
		logic [31:0] rd;
		regWrite(OFS_CTRL_ONE, 32'h0000_0000);
		regWrite(OFS_CTRL_TWO, 32'h0000_0004);
		i_hfc_pulse_source.drive(1'b1, 1'b0, 1'b0);
		repeat (6) @(posedge clk);
		n0 = irqCount;
		regWrite(OFS_CTRL_ONE, 32'h0000_0016);
		repeat (4) @(posedge clk);
		check("start irq", 32'(n0 + 1), 32'(irqCount));
		regRead(OFS_STATUS, 32'h0000_0000);
		regWrite(OFS_CTRL_ONE, 32'h0000_0000);
		repeat (4) @(posedge clk);
		check("stop irq", 32'(n0 + 2), 32'(irqCount));
		// Software judges the result here, never the window flag.
		bus(1'b0, OFS_RESULT, 32'h0000_0000, rd);
		check("pw count", 32'h1, 32'(rd != 32'h0 && rd <= 32'h2));
		i_hfc_pulse_source.drive(1'b0, 1'b0, 1'b0);
	endtask
	// Internal gate on the slow source: 16 slow ticks of 2 cycles each.
	task automatic test_internal_gate();
		int t0;
		int t1;
		int t2;
		regWrite(OFS_PERIOD, 32'h0000_00EF);
		regWrite(OFS_CTRL_TWO, 32'h0000_0085);
		regWrite(OFS_CTRL_ONE, 32'h0000_000A);
		waitIrq(t0);
		waitIrq(t1);
		waitIrq(t2);
		check("high length", 32'd64, 32'(t1 - t0));
		check("low length", 32'd32, 32'(t2 - t1));
		regWrite(OFS_CTRL_ONE, 32'h0000_0000);
	endtask
	// Companion wave as gate and on the pin, then the reserved source.
	task automatic test_companion();
		regWrite(OFS_CTRL_TWO, 32'h0000_0002);
		regWrite(OFS_CTRL_ONE, 32'h0000_000A);
		i_hfc_pulse_source.drive(1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge clk);
		check("pin driven", 32'h1, {31'h0, gateOutputPin});
		regRead(OFS_STATUS, 32'h0000_0080);
		regWrite(OFS_CTRL_TWO, 32'h0000_0042);
		repeat (3) @(posedge clk);
		check("pin quiet", 32'h0, {31'h0, gateOutputPin});
		regRead(OFS_STATUS, 32'h0000_0080);
		regWrite(OFS_CTRL_TWO, 32'h0000_0003);
		repeat (3) @(posedge clk);
		regRead(OFS_STATUS, 32'h0000_0000);
		i_hfc_pulse_source.drive(1'b0, 1'b0, 1'b0);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		test_reset_regs();
		test_freq_pin();
		test_const_input();
		test_pulse_width();
		test_internal_gate();
		test_companion();
		print_verdict();
	end
	// The whole run needs a few hundred cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
